// >>> hw/current_dac_control_decode.sv
// Control decode for one current-output DAC channel with an AXI4-Lite register slave.
// Assumes a single 50 MHz core clock and a one-cycle timer tick on the same clock.
// What this block does
// RQ1 - Control bits 15 to 9 are reserved and have no effect.
// RQ2 - Bits 8:7 pick shuffle scheme: step, internal counter, input code; 11 reserved.
// RQ3 - Software uses shuffling only for ac precision, not dc accuracy.
// RQ4 - Bit 6 enables upper-segment shuffle, bit 5 lower-segment shuffle.
// RQ5 - Bit 4 powers down output stage to high impedance; resets to one.
// RQ6 - With bit 3 set, output refreshes from data register on timer ticks.
// RQ7 - Bit 2 low forces data register to zero; high allows conversion.
// RQ8 - Software keeps control bit 1 at zero.
// RQ9 - With bit 3 clear, output refreshes from data register every core clock.
// RQ10 - Control writes act on the next clock edge; reserved bits read zero.
`timescale 1ns/100ps
`include "current_dac_map.svh"

module current_dac_control_decode (
    input  wire logic                      clock,
    input  wire logic                      nrst,
    input  wire logic [11:0]               s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic      [1:0]                s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [11:0]               s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic      [31:0]               s_axi_rdata,
    output logic      [1:0]                s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    input  wire logic                      firstTimerTick,
    output logic      [`DATA_WIDTH-1:0]    dacCode,
    output logic                           outputStagePowerDown,
    output logic                           outputEnable,
    output logic      [1:0]                shuffleSchemeSelect,
    output logic                           upperSegmentShuffleEn,
    output logic                           lowerSegmentShuffleEn,
    output logic                           shuffleSchemeValid
);

    // Whole state of the slave and its registers, registered as one word.
    typedef struct packed {
        logic                   awHeld;
        logic [11:0]            awAddr;
        logic                   wHeld;
        logic [31:0]            wData;
        logic [3:0]             wStrb;
        logic                   bValid;
        logic [1:0]             bResp;
        logic                   rValid;
        logic [1:0]             rResp;
        logic [31:0]            rData;
        logic [15:0]            ctrl;
        logic [`DATA_WIDTH-1:0] data;
    } dec_state_t;

    dec_state_t                  state_ff;
    dec_state_t                  nxt_state;
    current_dac_pkg::ctrl_fields_t fields;
    logic [15:0]                 wrCtrl;
    logic [`DATA_WIDTH-1:0]      codeOut;

    // Field decode; the reserved high bits are never looked at.
    assign fields.scheme         = current_dac_pkg::shuffle_scheme_t'(
                                   state_ff.ctrl[`MODE_HI:`MODE_LO]); // RQ2
    assign fields.upperShuffleEn = state_ff.ctrl[`UPPER_SHUF_BIT]; // RQ4
    assign fields.lowerShuffleEn = state_ff.ctrl[`LOWER_SHUF_BIT]; // RQ4
    assign fields.powerDown      = state_ff.ctrl[`POWER_DOWN_BIT]; // RQ5
    assign fields.timerUpdate    = state_ff.ctrl[`UPDATE_SRC_BIT];
    assign fields.clearN         = state_ff.ctrl[`CLEAR_N_BIT];
    assign fields.modeBit        = state_ff.ctrl[`MODE_BIT];

    // Merge byte lanes of the pending write into the control word.
    always_comb begin
        wrCtrl = state_ff.ctrl;
        if (state_ff.wStrb[0]) begin
            wrCtrl[7:0] = state_ff.wData[7:0];
        end
        if (state_ff.wStrb[1]) begin
            wrCtrl[15:8] = state_ff.wData[15:8];
        end
        wrCtrl = wrCtrl & `CTRL_LIVE_MASK; // RQ1
    end

    // Bus handshakes and register updates. Address and data are caught separately,
    // so the master may present them in either order; the write commits once both are held.
    always_comb begin
        nxt_state = state_ff;
        if (s_axi_awvalid && !state_ff.awHeld) begin
            nxt_state.awHeld = 1'b1;
            nxt_state.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !state_ff.wHeld) begin
            nxt_state.wHeld = 1'b1;
            nxt_state.wData = s_axi_wdata;
            nxt_state.wStrb = s_axi_wstrb;
        end
        if (state_ff.bValid && s_axi_bready) begin
            nxt_state.bValid = 1'b0;
        end
        if (state_ff.awHeld && state_ff.wHeld && !state_ff.bValid) begin
            nxt_state.awHeld = 1'b0;
            nxt_state.wHeld  = 1'b0;
            nxt_state.bValid = 1'b1;
            nxt_state.bResp  = `RESP_OKAY;
            unique case (state_ff.awAddr & `ADDR_WORD_MASK)
                `CTRL_OFFSET: begin
                    nxt_state.ctrl = wrCtrl; // RQ10
                end
                `DATA_OFFSET: begin
                    if (state_ff.wStrb[0]) begin
                        nxt_state.data[7:0] = state_ff.wData[7:0];
                    end
                    if (state_ff.wStrb[1]) begin
                        nxt_state.data[`DATA_WIDTH-1:8] = state_ff.wData[`DATA_WIDTH-1:8];
                    end
                end
                `OUT_OFFSET: begin
                    nxt_state.bResp = `RESP_SLVERR;
                end
                default: begin
                    nxt_state.bResp = `RESP_SLVERR;
                end
            endcase
        end
        // The clear bit holds the data register at zero for as long as it is low.
        if (!nxt_state.ctrl[`CLEAR_N_BIT]) begin
            nxt_state.data = `DATA_RESET; // RQ7
        end
        if (state_ff.rValid && s_axi_rready) begin
            nxt_state.rValid = 1'b0;
        end
        if (s_axi_arvalid && !state_ff.rValid) begin
            nxt_state.rValid = 1'b1;
            nxt_state.rResp  = `RESP_OKAY;
            nxt_state.rData  = 32'h0000_0000;
            unique case (s_axi_araddr & `ADDR_WORD_MASK)
                `CTRL_OFFSET: begin
                    nxt_state.rData[15:0] = state_ff.ctrl; // RQ10
                end
                `DATA_OFFSET: begin
                    nxt_state.rData[`DATA_WIDTH-1:0] = state_ff.data;
                end
                `OUT_OFFSET: begin
                    nxt_state.rData[`DATA_WIDTH-1:0] = codeOut;
                end
                default: begin
                    nxt_state.rResp = `RESP_SLVERR;
                end
            endcase
        end
    end

    // Power-on state: output stage powered down, clear active, all else zero.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_ff      <= '0;
            state_ff.ctrl <= `CTRL_RESET; // RQ5
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Refresh stage chooses between core clock and timer tick.
    current_dac_update u_update (
        .clock       (clock),
        .nrst        (nrst),
        .timerUpdate (fields.timerUpdate),
        .timerTick   (firstTimerTick),
        .clearN      (fields.clearN),
        .dataReg     (state_ff.data),
        .dacCode     (codeOut)
    );

    assign s_axi_awready         = !state_ff.awHeld;
    assign s_axi_wready          = !state_ff.wHeld;
    assign s_axi_bvalid          = state_ff.bValid;
    assign s_axi_bresp           = state_ff.bResp;
    assign s_axi_arready         = !state_ff.rValid;
    assign s_axi_rvalid          = state_ff.rValid;
    assign s_axi_rresp           = state_ff.rResp;
    assign s_axi_rdata           = state_ff.rData;
    assign dacCode               = codeOut;
    assign outputStagePowerDown  = fields.powerDown; // RQ5
    assign outputEnable          = !fields.powerDown; // RQ5
    assign shuffleSchemeSelect   = fields.scheme;
    assign upperSegmentShuffleEn = fields.upperShuffleEn;
    assign lowerSegmentShuffleEn = fields.lowerShuffleEn;
    // Code 11 is reserved, so the scheme is flagged invalid there.
    assign shuffleSchemeValid    = (fields.scheme != current_dac_pkg::SHUF_RSVD); // RQ2

endmodule

// >>> hw/current_dac_map.svh
// Register offsets, field positions, reset values and response codes for the DAC control block.
// Assumes it is included by bare name from hw/ sources; defines only, no logic.
`ifndef CURRENT_DAC_MAP_SVH
`define CURRENT_DAC_MAP_SVH

`define CTRL_OFFSET        12'h000
`define DATA_OFFSET        12'h004
`define OUT_OFFSET         12'h008
`define ADDR_WORD_MASK     12'hFFC
`define CTRL_RESET         16'h0010
`define CTRL_LIVE_MASK     16'h01FE
`define MODE_HI            8
`define MODE_LO            7
`define UPPER_SHUF_BIT     6
`define LOWER_SHUF_BIT     5
`define POWER_DOWN_BIT     4
`define UPDATE_SRC_BIT     3
`define CLEAR_N_BIT        2
`define MODE_BIT           1
`define DATA_WIDTH         11
`define DATA_RESET         11'h000
`define RESP_OKAY          2'b00
`define RESP_SLVERR        2'b10

`endif

// >>> hw/current_dac_pkg.sv
// Types shared by the DAC control block files.
// Assumes current_dac_map.svh is compiled alongside.
package current_dac_pkg;

    // Shuffle schemes selectable in the control word.
    typedef enum logic [1:0] {
        SHUF_STEP    = 2'b00,
        SHUF_COUNTER = 2'b01,
        SHUF_CODE    = 2'b10,
        SHUF_RSVD    = 2'b11
    } shuffle_scheme_t;

    // Decoded control fields handed to the output stage.
    typedef struct packed {
        shuffle_scheme_t scheme;
        logic            upperShuffleEn;
        logic            lowerShuffleEn;
        logic            powerDown;
        logic            timerUpdate;
        logic            clearN;
        logic            modeBit;
    } ctrl_fields_t;

endpackage

// >>> hw/current_dac_update.sv
// Output refresh stage: copies the data register to the converter input.
// Assumes timerTick is a one-cycle pulse synchronous to clock.
`timescale 1ns/100ps
`include "current_dac_map.svh"

module current_dac_update (
    input  wire logic                      clock,
    input  wire logic                      nrst,
    input  wire logic                      timerUpdate,
    input  wire logic                      timerTick,
    input  wire logic                      clearN,
    input  wire logic [`DATA_WIDTH-1:0]    dataReg,
    output logic      [`DATA_WIDTH-1:0]    dacCode
);

    typedef struct packed {
        logic [`DATA_WIDTH-1:0] code;
    } upd_state_t;

    upd_state_t state_ff;
    upd_state_t nxt_state;

    // Refresh every core clock, or only on timer ticks when selected.
    always_comb begin
        nxt_state = state_ff;
        if (!clearN) begin
            nxt_state.code = `DATA_RESET; // RQ7
        end else if (timerUpdate) begin
            if (timerTick) begin
                nxt_state.code = dataReg; // RQ6
            end
        end else begin
            nxt_state.code = dataReg; // RQ9
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign dacCode = state_ff.code;

endmodule

// >>> tb/current_dac_control_decode_asserts.sv
// Port checks for the DAC control block: bus handshakes and decoded outputs.
// Assumes it is bound to current_dac_control_decode and sees only its ports.
`timescale 1ns/100ps
module current_dac_control_decode_asserts (
    input wire logic       clock,
    input wire logic       nrst,
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic       s_axi_rready,
    input wire logic       outputStagePowerDown,
    input wire logic       outputEnable,
    input wire logic [1:0] shuffleSchemeSelect,
    input wire logic       shuffleSchemeValid
);
    // One clock domain, so every check shares one clock and is void in reset.
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    property p_oe; outputEnable == !outputStagePowerDown; endproperty
    a_oe: assert property (p_oe) else $error("enable not inverse of power down");
    property p_pd_rst; $rose(nrst) |-> outputStagePowerDown; endproperty
    a_pd_rst: assert property (p_pd_rst) else $error("power down not set after reset");
    property p_valid; shuffleSchemeValid == (shuffleSchemeSelect != 2'b11); endproperty
    a_valid: assert property (p_valid) else $error("scheme valid flag wrong");
    property p_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid;
    endproperty
    a_wr: assert property (p_wr) else $error("write answer late");
    property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rd: assert property (p_rd) else $error("read answer late");
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_bhold: assert property (p_bhold) else $error("write answer dropped");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
    a_rhold: assert property (p_rhold) else $error("read answer dropped");
    property p_arrdy; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_arrdy: assert property (p_arrdy) else $error("read address taken while busy");
endmodule

bind current_dac_control_decode current_dac_control_decode_asserts chk_i (.*);

// >>> tb/tb_current_dac_control_decode.sv
// Self-checking bench for the DAC control block over its register bus.
// Assumes the map header and the block sources are compiled first.
`timescale 1ns/100ps
`include "current_dac_map.svh"
module tb_current_dac_control_decode;
    logic                     clock = 1'b0, nrst = 1'b0, firstTimerTick = 1'b0;
    logic [11:0]              s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0]              s_axi_wdata = '0, s_axi_rdata;
    logic [3:0]               s_axi_wstrb = 4'hf;
    logic                     s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic                     s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic                     s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic                     s_axi_rvalid, outputStagePowerDown, outputEnable;
    logic                     upperSegmentShuffleEn, lowerSegmentShuffleEn, shuffleSchemeValid;
    logic [1:0]               s_axi_bresp, s_axi_rresp, shuffleSchemeSelect;
    logic [`DATA_WIDTH-1:0]   dacCode;
    int                       n_mismatch = 0, num_checks = 0;

    current_dac_control_decode uut (.*);

    // Free-running core clock.
    always #10 clock = ~clock;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Flags are sampled at the falling edge, so no race with the rising edge updates.
    // Ready is raised late on purpose to make the slave hold its answer a cycle.
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw, w, b;
        logic [1:0] rs;
        int n;
        n = 0;
        b = 1'b0;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!b) begin
            @(negedge clock);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bready && s_axi_bvalid;
            rs = s_axi_bresp;
            @(posedge clock);
            n++;
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (n == 3) s_axi_bready <= 1'b1;
            if (b) s_axi_bready <= 1'b0;
        end
        chk(rs, er);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ar, r;
        logic [31:0] d;
        logic [1:0] rs;
        int n;
        n = 0;
        r = 1'b0;
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        while (!r) begin
            @(negedge clock);
            ar = s_axi_arvalid && s_axi_arready;
            r = s_axi_rready && s_axi_rvalid;
            d = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge clock);
            n++;
            if (ar) s_axi_arvalid <= 1'b0;
            if (n == 2) s_axi_rready <= 1'b1;
            if (r) s_axi_rready <= 1'b0;
        end
        chk(d, ed);
        chk(rs, er);
    endtask

    // Main sequence; every expectation comes from the register map and the values written.
    initial begin
        repeat (20) @(posedge clock);
        nrst <= 1'b1;
        rd(`CTRL_OFFSET, 32'h0000_0010, `RESP_OKAY);
        chk(outputEnable, 1'b0);
        for (int m = 0; m < 4; m++) begin
            // Each shuffle enable moves on its own, so swapped or stuck bits show up.
            wr(`CTRL_OFFSET, 32'hffff_fe04 | (m << 5) | (m << 7), `RESP_OKAY);
            rd(`CTRL_OFFSET, 32'h0000_0004 | (m << 5) | (m << 7), `RESP_OKAY);
            chk(shuffleSchemeSelect, m[1:0]);
            chk(shuffleSchemeValid, m != 3);
            chk({upperSegmentShuffleEn, lowerSegmentShuffleEn, outputEnable},
                {m[1], m[0], 1'b1});
        end
        // Shuffling stays off while the dc output path is checked.
        wr(`CTRL_OFFSET, 32'h0000_0004, `RESP_OKAY);
        wr(`DATA_OFFSET, 32'hffff_f5a5, `RESP_OKAY);
        rd(`OUT_OFFSET, 32'h0000_05a5, `RESP_OKAY);
        chk(dacCode, 11'h5a5);
        wr(`OUT_OFFSET, 32'h0000_0000, `RESP_SLVERR);
        wr(12'h010, 32'h0000_0000, `RESP_SLVERR);
        rd(12'h00c, 32'h0000_0000, `RESP_SLVERR);
        wr(`CTRL_OFFSET, 32'h0000_000c, `RESP_OKAY);
        wr(`DATA_OFFSET, 32'h0000_0123, `RESP_OKAY);
        repeat (3) @(negedge clock);
        chk(dacCode, 11'h5a5);
        @(posedge clock);
        firstTimerTick <= 1'b1;
        @(posedge clock);
        firstTimerTick <= 1'b0;
        @(negedge clock);
        chk(dacCode, 11'h123);
        wr(`CTRL_OFFSET, 32'h0000_0008, `RESP_OKAY);
        wr(`DATA_OFFSET, 32'h0000_07ff, `RESP_OKAY);
        rd(`DATA_OFFSET, 32'h0000_0000, `RESP_OKAY);
        chk(dacCode, 11'h000);
        // The mode bit is always written as zero by software.
        wr(`CTRL_OFFSET, 32'h0000_0014, `RESP_OKAY);
        rd(`CTRL_OFFSET, 32'h0000_0014, `RESP_OKAY);
        chk({outputStagePowerDown, outputEnable}, 2'h2);
        report_and_stop();
    end

    // Watchdog well beyond the roughly 130 cycles the tests need.
    initial begin
        #100_000;
        n_mismatch++;
        report_and_stop();
    end
endmodule
